/* File: serial_irq_host.sv */
// host end of the serial interrupt link, makes the link clock by division
`timescale 1ns/1ns
module serial_irq_host
    import serirq_pkg::*;
(
    serirq_if.host                  link,
    input  wire logic               clk,
    input  wire logic               arst_n,
    input  wire logic               cycle_req,
    input  wire logic               quiet_next,
    input  wire logic [3:0]         start_width,
    output logic [USED_FRAMES-1:0]  irq_state,
    output logic                    cycle_done,
    output logic                    quiet_mode,
    output logic                    busy
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic                   ls1;
        logic                   ls2;
        logic [DIV_W-1:0]       div;
        logic                   clk_o;
        host_state_t            st;
        logic [3:0]             cnt;
        logic [FR_W-1:0]        fr;
        logic [1:0]             ph;
        logic                   quiet;
        logic                   first_done;
        logic                   pend;
        logic [USED_FRAMES-1:0] cap;
        logic [USED_FRAMES-1:0] irq;
        logic                   done;
        logic                   oe;
        logic                   dout;
    } host_regs_t;

    host_regs_t q_r;
    host_regs_t q_nxt;

    logic       tick;
    logic [3:0] sw;

    assign tick = (q_r.div == DIV_W'(LINK_DIV - 1));
    assign sw   = (start_width < START_MIN) ? START_MIN :
                  (start_width > START_MAX) ? START_MAX : start_width;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic            idle_chk;
        logic [FR_W-1:0] idx;
        idle_chk = 1'b0;
        idx      = '0;
        q_nxt    = q_r;

        q_nxt.ls1  = link.shared_irq_serial_line;
        q_nxt.ls2  = q_r.ls1;
        q_nxt.done = 1'b0;
        q_nxt.div  = tick ? '0 : q_r.div + DIV_W'(1);
        // link clock rises on the clk edge that starts each tick, so host drives move one clk after the rising link edge
        q_nxt.clk_o = (DIV_W'(q_nxt.div + DIV_W'(1)) < DIV_W'(LINK_HALF));
        if (cycle_req) begin
            q_nxt.pend = 1'b1;
        end

        if (tick) begin
            q_nxt.oe   = 1'b0;
            q_nxt.dout = 1'b1;
            case (q_r.st)
                HOST_IDLE: begin
                    idle_chk = 1'b1;
                end
                HOST_START, HOST_STOP: begin
                    q_nxt.oe = 1'b1;
                    if (q_r.cnt == 4'h1) begin
                        q_nxt.st = (q_r.st == HOST_START) ? HOST_START_HI : HOST_STOP_HI;
                    end else begin
                        q_nxt.cnt  = q_r.cnt - 4'h1;
                        q_nxt.dout = 1'b0;
                    end
                end
                HOST_START_HI: begin
                    q_nxt.st = HOST_FRAMES;
                    q_nxt.ph = PH_TURN;
                    q_nxt.fr = '0;
                end
                HOST_FRAMES: begin
                    if (q_r.ph == PH_SAMPLE && q_r.fr >= FIRST_FR && q_r.fr <= LAST_USED) begin
                        idx = q_r.fr - FIRST_FR;
                        q_nxt.cap[idx[4:0]] = ~q_r.ls2;
                    end
                    if (q_r.ph == PH_TURN) begin
                        q_nxt.ph = PH_SAMPLE;
                        q_nxt.fr = q_r.fr + FIRST_FR;
                        if (q_r.fr == LAST_FRAME) begin
                            q_nxt.st    = HOST_STOP;
                            q_nxt.cnt   = quiet_next ? STOP_QUIET : STOP_CONT;
                            q_nxt.quiet = quiet_next;
                            q_nxt.oe    = 1'b1;
                            q_nxt.dout  = 1'b0;
                            q_nxt.irq   = q_r.cap;
                            q_nxt.done  = 1'b1;
                        end
                    end else begin
                        q_nxt.ph = q_r.ph + 2'h1;
                    end
                end
                HOST_STOP_HI: begin
                    q_nxt.st = HOST_TURN;
                end
                HOST_TURN: begin
                    idle_chk = 1'b1;
                end
                default: begin
                    q_nxt.st = HOST_IDLE;
                end
            endcase

            if (idle_chk) begin
                q_nxt.st = HOST_IDLE;
                if (!q_r.ls2 && q_r.quiet) begin
                    // peripheral pulsed last clock; hold low for the rest
                    q_nxt.st   = HOST_START;
                    q_nxt.cnt  = sw - 4'h1;
                    q_nxt.oe   = 1'b1;
                    q_nxt.dout = 1'b0;
                end else if (!q_r.first_done || q_r.pend) begin
                    q_nxt.st         = HOST_START;
                    q_nxt.cnt        = sw;
                    q_nxt.oe         = 1'b1;
                    q_nxt.dout       = 1'b0;
                    q_nxt.first_done = 1'b1;
                    q_nxt.pend       = cycle_req;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign link.link_clk = q_r.clk_o;
    assign link.host_oe  = q_r.oe;
    assign link.host_out = q_r.dout;

    assign irq_state  = q_r.irq;
    assign cycle_done = q_r.done;
    assign quiet_mode = q_r.quiet;
    assign busy       = (q_r.st != HOST_IDLE) || q_r.pend || !q_r.first_done;

endmodule

/* File: serial_irq_peripheral.sv */
// peripheral end of the serial interrupt link, clocked by the link clock
`timescale 1ns/1ns
module serial_irq_peripheral
    import serirq_pkg::*;
(
    serirq_if.device                link,
    input  wire logic               arst_n,
    input  wire logic [USED_FRAMES-1:0] irq_active,
    input  wire logic [USED_FRAMES-1:0] frame_owned,
    output logic                    quiet_mode,
    output logic                    cycle_active,
    output logic [FR_W-1:0]         frame_num,
    output logic                    stop_bad
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [USED_FRAMES-1:0] irq_s1;
        logic [USED_FRAMES-1:0] irq_s2;
        logic [USED_FRAMES-1:0] rep;
        dev_state_t             st;
        logic [FR_W-1:0]        fr;
        logic [1:0]             ph;
        logic [3:0]             low_cnt;
        logic                   quiet;
        logic                   oe;
        logic                   dout;
        logic                   bad;
    } dev_regs_t;

    dev_regs_t q_r;
    dev_regs_t q_nxt;

    logic                   line;
    logic [USED_FRAMES-1:0] now_owned;
    logic                   pending;

    assign line      = link.shared_irq_serial_line;
    assign now_owned = q_r.irq_s2 & frame_owned;
    assign pending   = (now_owned != q_r.rep);

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [FR_W-1:0] idx;
        logic            own;
        idx   = '0;
        own   = 1'b0;
        q_nxt = q_r;

        // asynchronous sources pass two flip-flops
        q_nxt.irq_s1 = irq_active;
        q_nxt.irq_s2 = q_r.irq_s1;

        // released unless a phase below drives the line
        q_nxt.oe   = 1'b0;
        q_nxt.dout = 1'b1;

        case (q_r.st)
            DEV_IDLE: begin
                if (!line) begin
                    // host start, or another peripheral's quiet pulse
                    q_nxt.st = DEV_START;
                end else if (q_r.quiet && pending) begin
                    q_nxt.st   = DEV_PULSE;
                    q_nxt.oe   = 1'b1;
                    q_nxt.dout = 1'b0;
                end else begin
                    q_nxt.st = DEV_IDLE;
                end
            end

            DEV_PULSE: begin
                // one clock low only, host takes over after
                q_nxt.st = DEV_START;
            end

            DEV_START: begin
                if (line) begin
                    // first high clock ends the start pulse
                    q_nxt.st  = DEV_FRAMES;
                    q_nxt.ph  = PH_TURN;
                    q_nxt.fr  = '0;
                    q_nxt.rep = now_owned;
                end
            end

            DEV_FRAMES: begin
                if (q_r.ph == PH_TURN) begin
                    if (q_r.fr == LAST_FRAME) begin
                        q_nxt.st      = DEV_STOP;
                        q_nxt.low_cnt = '0;
                    end else begin
                        q_nxt.ph = PH_SAMPLE;
                        q_nxt.fr = q_r.fr + FIRST_FR;
                    end
                end else begin
                    q_nxt.ph = q_r.ph + 2'h1;
                end

                // frames 1..21 carry sources, the rest are unassigned
                if (q_nxt.st == DEV_FRAMES && q_nxt.fr >= FIRST_FR && q_nxt.fr <= LAST_USED) begin
                    idx = q_nxt.fr - FIRST_FR;
                    own = frame_owned[idx[4:0]];
                end

                if (own && q_nxt.ph == PH_SAMPLE && q_r.rep[idx[4:0]]) begin
                    q_nxt.oe   = 1'b1;
                    q_nxt.dout = 1'b0;
                end else if (own && q_nxt.ph == PH_RECOV) begin
                    q_nxt.oe   = 1'b1;
                    q_nxt.dout = 1'b1;
                end
            end

            DEV_STOP: begin
                if (!line) begin
                    if (q_r.low_cnt != START_MAX) begin
                        q_nxt.low_cnt = q_r.low_cnt + 4'h1;
                    end
                end else if (q_r.low_cnt != '0) begin
                    // stop width picks the next cycle's mode
                    q_nxt.quiet = (q_r.low_cnt == STOP_QUIET);
                    q_nxt.bad   = (q_r.low_cnt != STOP_QUIET) && (q_r.low_cnt != STOP_CONT);
                    q_nxt.st    = DEV_IDLE;
                end
            end

            default: begin
                q_nxt.st = DEV_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge link.link_clk or negedge arst_n) begin
        if (!arst_n) begin
            // continuous idle, line released, nothing reported yet
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign link.dev_oe  = q_r.oe;
    assign link.dev_out = q_r.dout;

    assign quiet_mode   = q_r.quiet;
    assign cycle_active = (q_r.st == DEV_FRAMES);
    assign frame_num    = q_r.fr;
    assign stop_bad     = q_r.bad;

endmodule

/* File: serirq_chk.sv */
// assertions on the shared serial interrupt line
`timescale 1ns/1ns
module serirq_chk (
    input wire logic link_clk,
    input wire logic arst_n,
    input wire logic dev_oe,
    input wire logic dev_out,
    input wire logic host_oe,
    input wire logic host_out,
    input wire logic shared_irq_serial_line
);
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!arst_n);
    typedef struct packed {
        logic       frm;
        logic [6:0] cnt;
        logic [3:0] lo;
    } track_t;
    logic   dev_lo, dev_hi, host_lo, host_hi;
    track_t st_r, st_nxt;
    assign dev_lo  = dev_oe & ~dev_out;
    assign dev_hi  = dev_oe & dev_out;
    assign host_lo = host_oe & ~host_out;
    assign host_hi = host_oe & host_out;
    ////////////////////////////////////////////////////////////////
    // clocks since the last host high, and inside-frames flag
    always_comb begin
        st_nxt = st_r;
        if (host_hi) begin
            st_nxt.frm = ~st_r.frm;
            st_nxt.cnt = 7'h01;
        end else if (st_r.cnt != 7'h7f) begin
            st_nxt.cnt = st_r.cnt + 7'h01;
        end
        // consecutive host low clocks, saturating
        if (host_lo) begin
            if (st_r.lo != 4'hf) begin
                st_nxt.lo = st_r.lo + 4'h1;
            end
        end else begin
            st_nxt.lo = 4'h0;
        end
    end
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence host_low_ends;
        $fell(host_lo) ##0 host_hi;
    endsequence
    sequence host_lets_go;
        !host_oe;
    endsequence
    no_contention_a: assert property (!(dev_oe && host_oe && (dev_out != host_out)))
        else $error("both ends drive opposite levels");
    dev_low_one_a: assert property (dev_lo |=> !dev_lo)
        else $error("peripheral low longer than one clock");
    dev_high_free_a: assert property (dev_hi |=> !dev_oe)
        else $error("peripheral kept driving after recovery");
    host_low_max_a: assert property (host_lo |-> st_r.lo < 4'h8)
        else $error("host low longer than eight clocks");
    start_min_a: assert property ($rose(host_lo) && !st_r.frm |-> host_lo [*3])
        else $error("start pulse too short");
    low_end_a: assert property ($fell(host_lo) |-> host_low_ends ##1 host_lets_go)
        else $error("host low not followed by one high then release");
    start_turn_a: assert property (host_hi && !st_r.frm |=> !host_oe && !dev_oe && shared_irq_serial_line)
        else $error("line not released after start");
    sample_slot_a: assert property (dev_lo && st_r.frm |-> st_r.cnt % 3 == 2 && st_r.cnt <= 7'd62)
        else $error("peripheral low outside a sample phase");
    recov_slot_a: assert property (dev_hi |-> st_r.frm && st_r.cnt % 3 == 0 && st_r.cnt >= 7'd3 && st_r.cnt <= 7'd63)
        else $error("peripheral high outside a recovery phase");
    stop_place_a: assert property ($rose(host_lo) && st_r.frm |-> st_r.cnt == 7'd98)
        else $error("stop not after frame 32");
    stop_width_a: assert property ($rose(host_lo) && st_r.frm |=> host_lo ##2 !host_lo)
        else $error("stop width not 2 or 3");
endmodule

/* File: serirq_if.sv */
// interface joining the peripheral and host ends of the shared interrupt line
`timescale 1ns/1ns
interface serirq_if;
    logic link_clk;
    logic dev_oe;
    logic dev_out;
    logic host_oe;
    logic host_out;
    logic shared_irq_serial_line;

    // wired-and with pull-up: any enabled low driver wins
    assign shared_irq_serial_line = ~((dev_oe & ~dev_out) | (host_oe & ~host_out));

    modport device (
        input  link_clk,
        input  shared_irq_serial_line,
        output dev_oe,
        output dev_out
    );

    modport host (
        output link_clk,
        input  shared_irq_serial_line,
        output host_oe,
        output host_out
    );
endinterface

/* File: serirq_pkg.sv */
// constants and types shared by both ends of the serial interrupt link
package serirq_pkg;

    localparam int CLK_PERIOD_NS  = 4;
    localparam int LINK_PERIOD_NS = 32;
    localparam int LINK_DIV       = LINK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int LINK_HALF      = LINK_DIV / 2;
    localparam int DIV_W          = $clog2(LINK_DIV);

    localparam int FRAME_COUNT    = 32;
    localparam int USED_FRAMES    = 21;
    localparam int FR_W           = 6;

    localparam logic [FR_W-1:0] LAST_FRAME = 6'h20;
    localparam logic [FR_W-1:0] LAST_USED  = 6'h15;
    localparam logic [FR_W-1:0] FIRST_FR   = 6'h01;

    // frame numbers of the named sources
    localparam int SYSTEM_MGMT_INTERRUPT_FRAME = 3;
    localparam int IO_CHANNEL_CHECK_FRAME      = 17;
    localparam int PCI_INTERRUPT_A_FRAME       = 18;
    localparam int PCI_INTERRUPT_D_FRAME       = 21;

    localparam logic [1:0] PH_SAMPLE = 2'h0;
    localparam logic [1:0] PH_RECOV  = 2'h1;
    localparam logic [1:0] PH_TURN   = 2'h2;

    localparam logic [3:0] START_MIN  = 4'h4;
    localparam logic [3:0] START_MAX  = 4'h8;
    localparam logic [3:0] STOP_QUIET = 4'h2;
    localparam logic [3:0] STOP_CONT  = 4'h3;

    typedef enum logic [2:0] {
        DEV_IDLE   = 3'b000,
        DEV_PULSE  = 3'b001,
        DEV_START  = 3'b010,
        DEV_FRAMES = 3'b011,
        DEV_STOP   = 3'b100
    } dev_state_t;

    typedef enum logic [2:0] {
        HOST_IDLE     = 3'b000,
        HOST_START    = 3'b001,
        HOST_START_HI = 3'b010,
        HOST_FRAMES   = 3'b011,
        HOST_STOP     = 3'b100,
        HOST_STOP_HI  = 3'b101,
        HOST_TURN     = 3'b110
    } host_state_t;

endpackage

/* File: tb_top.sv */
// self-checking bench joining host and peripheral ends
`timescale 1ns/1ns
module tb_top
    import serirq_pkg::*;
;
    logic                   clk, arst_n, cycle_req, quiet_next;
    logic [3:0]             start_width;
    logic [USED_FRAMES-1:0] irq_active, frame_owned, irq_state;
    logic                   cycle_done, h_quiet, busy, d_quiet, cycle_active, stop_bad;
    logic [FR_W-1:0]        frame_num;
    logic [3:0]             widths [4];
    int                     failures, check_count, k;
    serirq_if lnk ();
    serial_irq_host serial_irq_host_i (.link(lnk), .clk(clk), .arst_n(arst_n), .cycle_req(cycle_req),
        .quiet_next(quiet_next), .start_width(start_width), .irq_state(irq_state),
        .cycle_done(cycle_done), .quiet_mode(h_quiet), .busy(busy));
    serial_irq_peripheral serial_irq_peripheral_i (.link(lnk), .arst_n(arst_n), .irq_active(irq_active),
        .frame_owned(frame_owned), .quiet_mode(d_quiet), .cycle_active(cycle_active),
        .frame_num(frame_num), .stop_bad(stop_bad));
    serirq_chk serirq_chk_i (.link_clk(lnk.link_clk), .arst_n(arst_n), .dev_oe(lnk.dev_oe),
        .dev_out(lnk.dev_out), .host_oe(lnk.host_oe), .host_out(lnk.host_out),
        .shared_irq_serial_line(lnk.shared_irq_serial_line));
    ////////////////////////////////////////////////////////////////
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    function automatic logic [USED_FRAMES-1:0] exp_state(input logic [USED_FRAMES-1:0] a,
                                                          input logic [USED_FRAMES-1:0] o);
        return a & o;
    endfunction
    task automatic chk(input logic [USED_FRAMES-1:0] seen, input logic [USED_FRAMES-1:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic end_of_test();
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cycle_done !== 1'b1 && n < 2400);
        chk(USED_FRAMES'(n < 2400), 21'h000001, "cycle end timeout");
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        repeat (3 * LINK_DIV) @(negedge clk);
    endtask
    task automatic pulse_req();
        cycle_req = 1'b1;
        @(negedge clk);
        cycle_req = 1'b0;
    endtask
    task automatic check_modes(input logic q);
        chk(USED_FRAMES'(h_quiet), USED_FRAMES'(q), "host mode");
        chk(USED_FRAMES'(d_quiet), USED_FRAMES'(q), "peripheral mode");
        chk(USED_FRAMES'(stop_bad), 21'h000000, "stop width flag");
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        failures++;
        end_of_test();
    end
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        cycle_req = 1'b0;
        quiet_next = 1'b0;
        start_width = 4'h4;
        widths = '{4'h4, 4'h8, 4'h0, 4'hf};
        failures = 0;
        check_count = 0;
        irq_active = USED_FRAMES'($urandom(35012));
        frame_owned = USED_FRAMES'($urandom()) | 21'h000001;
        repeat (LINK_DIV) @(negedge clk);
        check_modes(1'b0);
        arst_n = 1'b1;
        @(negedge clk);
        chk(irq_state, 21'h000000, "defaults before first cycle");
        wait_done();
        chk(irq_state, exp_state(irq_active, frame_owned), "first cycle");
        wait_idle();
        check_modes(1'b0);
        for (int i = 0; i < 12; i++) begin
            start_width = (i < 4) ? widths[i] : 4'($urandom());
            quiet_next = 1'($urandom());
            if (h_quiet === 1'b1) begin
                k = $urandom() % USED_FRAMES;
                irq_active = irq_active ^ (frame_owned[k] ? (21'h000001 << k) : 21'h000001);
            end else begin
                irq_active = USED_FRAMES'($urandom());
                pulse_req();
            end
            wait_done();
            chk(irq_state, exp_state(irq_active, frame_owned), "frame states");
            wait_idle();
            check_modes(quiet_next);
        end
        quiet_next = 1'b0;
        pulse_req();
        wait_done();
        wait_idle();
        irq_active = irq_active ^ 21'h000001;
        repeat (200 * LINK_DIV) @(negedge clk);
        chk(USED_FRAMES'(busy), 21'h000000, "no start in continuous mode");
        pulse_req();
        for (int j = 0; j < 2; j++) begin
            wait_done();
            chk(irq_state, exp_state(irq_active, frame_owned), "back to back");
            if (j == 0) begin
                irq_active = irq_active ^ 21'h100001;
                pulse_req();
            end
        end
        wait_idle();
        quiet_next = 1'b1;
        pulse_req();
        wait_done();
        wait_idle();
        check_modes(1'b1);
        irq_active = irq_active ^ 21'h000001;
        repeat (50 * LINK_DIV) @(negedge clk);
        chk(USED_FRAMES'(cycle_active), 21'h000001, "quiet start by peripheral");
        arst_n = 1'b0;
        repeat (LINK_DIV) @(negedge clk);
        check_modes(1'b0);
        arst_n = 1'b1;
        wait_done();
        chk(irq_state, exp_state(irq_active, frame_owned), "first cycle after reset");
        end_of_test();
    end
endmodule
